// *** core/mmcp_top.sv ***
/*
  mmcp_top: address decode for the core, sharing of the program memory
  port between core, vector fetch and serial programmer, and evaluation
  of the code protect byte.
  assumes: program memory and sfr blocks sit outside and return read data
  in the same cycle as their registered read strobe; all inputs are
  synchronous to i_core_clk.
*/
`timescale 1ns/1ps
`include "mmcp_cfg.svh"

// Overview of operation
// RULE1: zero page 0x0000-0x00FF holds the sfr block and the start of ram.
// RULE2: zero page form takes one operand byte, page 0x00 implied.
// RULE3: special page 0xFF00-0xFFFF reached through its own addressing form.
// RULE4: special page form takes one operand byte, page 0xFF implied.
// RULE5: lowest 128 and highest 2 program bytes are test area, rest user.
// RULE6: reset and interrupt vectors are fetched from the vector area.
// RULE7: program byte 0xFFDB is the code protect setting.
// RULE8: protect byte 0x00 blocks programmer reads and writes.
// RULE9: protect byte 0xFF leaves programmer access open.
// RULE10: programmer protects a blank part by writing 0x00 to the protect byte.
// RULE11: ram is not cleared at reset; software sets it first.
// RULE12: software never touches sfr addresses with no register.
// RULE13: protect byte read after reset; anything but 0x00 means open.
// RULE14: protected programmer reads return filler, writes change nothing.
module mmcp_top (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire mmcp_pkg::mmcp_cpu_req_t i_cpu_req,
  output logic      [7:0]              o_cpu_rdata,
  output logic                         o_cpu_rvalid,
  output logic                         o_cpu_unmapped,
  output mmcp_pkg::mmcp_region_t       o_cpu_region,
  input  wire logic                    i_vec_req,
  input  wire logic [3:0]              i_vec_num,
  output logic      [15:0]             o_vec_addr,
  output logic                         o_vec_valid,
  output logic                         o_ready,
  input  wire mmcp_pkg::mmcp_prg_req_t i_prg_req,
  output logic                         o_prg_done,
  output logic                         o_prg_refused,
  output logic      [7:0]              o_prg_rdata,
  output logic                         o_prot_active,
  output logic      [15:0]             o_rom_addr,
  output logic                         o_rom_rd,
  output logic                         o_rom_wr,
  output logic      [7:0]              o_rom_wdata,
  input  wire logic [7:0]              i_rom_rdata,
  output logic      [`MMCP_SFR_AW-1:0] o_sfr_addr,
  output logic                         o_sfr_rd,
  output logic                         o_sfr_wr,
  output logic      [7:0]              o_sfr_wdata,
  input  wire logic [7:0]              i_sfr_rdata
);

  mmcp_pkg::mmcp_state_t  state_reg;
  mmcp_pkg::mmcp_state_t  state_next;
  mmcp_pkg::mmcp_tag_t    tag_reg;
  mmcp_pkg::mmcp_tag_t    tag_next;
  mmcp_pkg::mmcp_region_t s1_region_reg;
  logic                   s1_rd_reg;
  logic                   s1_acc_reg;
  logic                   prot_reg;
  logic [3:0]             vec_num_reg;
  logic [7:0]             vec_lo_reg;
  logic [7:0]             ram_q;

  function automatic mmcp_pkg::mmcp_region_t f_region(input logic [15:0] a);
    mmcp_pkg::mmcp_region_t r;
    r = mmcp_pkg::RG_NONE;
    if (a <= `MMCP_SFR_LAST) begin
      // empty sfr slots decode to nothing and are flagged
      if (a == `MMCP_SFR_RSV0 || a == `MMCP_SFR_RSV1 || a == `MMCP_SFR_RSV2) begin
        r = mmcp_pkg::RG_NONE; // RULE12
      end else begin
        r = mmcp_pkg::RG_SFR; // RULE1
      end
    end else if (a >= `MMCP_RAM_BASE && a <= `MMCP_RAM_LAST) begin
      r = mmcp_pkg::RG_RAM; // RULE1
    end else if (a >= `MMCP_ROM_BASE) begin
      if (a <= `MMCP_TEST_LO_LAST || a >= `MMCP_TEST_HI_BASE) begin
        r = mmcp_pkg::RG_TEST; // RULE5
      end else if (a >= `MMCP_VEC_BASE) begin
        r = mmcp_pkg::RG_VEC; // RULE6
      end else begin
        r = mmcp_pkg::RG_ROM; // RULE5
      end
    end
    return r;
  endfunction

  // effective address of the core access
  wire logic                   am_zp    = (i_cpu_req.amode == mmcp_pkg::AM_ZP);
  wire logic                   am_sp    = (i_cpu_req.amode == mmcp_pkg::AM_SP);
  wire logic [15:0]            zp_ea    = {`MMCP_ZP_PAGE, i_cpu_req.addr[7:0]}; // RULE2
  wire logic [15:0]            sp_ea    = {`MMCP_SP_PAGE, i_cpu_req.addr[7:0]}; // RULE3 RULE4
  wire logic [15:0]            cpu_ea   = am_zp ? zp_ea : (am_sp ? sp_ea : i_cpu_req.addr);
  wire mmcp_pkg::mmcp_region_t cpu_rg   = f_region(cpu_ea);
  wire logic                   cpu_acc  = i_cpu_req.rd | i_cpu_req.wr;
  wire logic                   rg_prog  = (cpu_rg == mmcp_pkg::RG_ROM) | (cpu_rg == mmcp_pkg::RG_VEC) |
                                          (cpu_rg == mmcp_pkg::RG_TEST);
  wire logic                   rg_sfr   = (cpu_rg == mmcp_pkg::RG_SFR);
  wire logic                   rg_ram   = (cpu_rg == mmcp_pkg::RG_RAM);
  wire logic [15:0]            ram_off  = cpu_ea - `MMCP_RAM_BASE;
  wire logic                   ram_we   = i_cpu_req.wr & rg_ram;

  // program memory port: protect sample, vector fetch, core, programmer
  wire logic                   st_run   = (state_reg == mmcp_pkg::ST_RUN);
  wire logic                   prot_go  = (state_reg == mmcp_pkg::ST_PROT);
  wire logic                   vlo_go   = st_run & i_vec_req;
  wire logic                   vhi_go   = (state_reg == mmcp_pkg::ST_VEC);
  wire logic                   cpu_go   = i_cpu_req.rd & rg_prog & ~prot_go & ~vlo_go & ~vhi_go;
  wire logic                   prg_busy = (tag_reg == mmcp_pkg::TAG_PRG) | o_prg_done;
  wire logic                   prg_in   = (i_prg_req.addr >= `MMCP_ROM_BASE);
  // core fetches win the port; a programmer waits for an idle cycle
  wire logic                   prg_gnt  = st_run & i_prg_req.req & ~prg_busy & ~vlo_go & ~cpu_go;
  wire logic                   prg_ok   = prg_gnt & prg_in & ~prot_reg; // RULE8 RULE9
  wire logic                   prg_ref  = prg_gnt & ~(prg_in & ~prot_reg); // RULE14
  wire logic [15:0]            vlo_addr = `MMCP_VEC_BASE + {11'h000, i_vec_num, 1'b0}; // RULE6
  wire logic [15:0]            vhi_addr = `MMCP_VEC_BASE + {11'h000, vec_num_reg, 1'b1};
  wire logic                   rom_rd_n = prot_go | vlo_go | vhi_go | cpu_go | (prg_ok & ~i_prg_req.we);
  wire logic                   rom_wr_n = prg_ok & i_prg_req.we;
  wire logic [15:0]            rom_a_n  = prot_go ? `MMCP_PROT_ADDR :
                                          vlo_go  ? vlo_addr :
                                          vhi_go  ? vhi_addr :
                                          cpu_go  ? cpu_ea : i_prg_req.addr;

  // a programmer write of the protect-on value closes access at once
  wire logic                   prot_wr  = (tag_reg == mmcp_pkg::TAG_PRG) & o_rom_wr &
                                          (o_rom_addr == `MMCP_PROT_ADDR) & (o_rom_wdata == `MMCP_PROT_ON);

  always_comb begin
    tag_next = mmcp_pkg::TAG_NONE;
    if (prot_go) begin
      tag_next = mmcp_pkg::TAG_PROT;
    end else if (vlo_go) begin
      tag_next = mmcp_pkg::TAG_VLO;
    end else if (vhi_go) begin
      tag_next = mmcp_pkg::TAG_VHI;
    end else if (cpu_go) begin
      tag_next = mmcp_pkg::TAG_CPU;
    end else if (prg_ok) begin
      tag_next = mmcp_pkg::TAG_PRG;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mmcp_pkg::ST_PROT: begin
        state_next = mmcp_pkg::ST_PWAIT;
      end
      mmcp_pkg::ST_PWAIT: begin
        state_next = mmcp_pkg::ST_RUN;
      end
      mmcp_pkg::ST_RUN: begin
        if (i_vec_req) begin
          state_next = mmcp_pkg::ST_VEC;
        end
      end
      mmcp_pkg::ST_VEC: begin
        state_next = mmcp_pkg::ST_RUN;
      end
      default: begin
        state_next = mmcp_pkg::ST_PROT;
      end
    endcase
  end

  mmcp_ram u_ram (
    .i_core_clk (i_core_clk),
    .i_we       (ram_we),
    .i_addr     (ram_off[`MMCP_RAM_AW-1:0]),
    .i_wdata    (i_cpu_req.wdata),
    .o_rdata    (ram_q)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg   <= mmcp_pkg::ST_PROT;
      tag_reg     <= mmcp_pkg::TAG_NONE;
      o_rom_rd    <= 1'b0;
      o_rom_wr    <= 1'b0;
      o_rom_addr  <= 16'h0000;
      o_rom_wdata <= 8'h00;
      vec_num_reg <= 4'h0;
    end else begin
      state_reg   <= state_next;
      tag_reg     <= tag_next;
      o_rom_rd    <= rom_rd_n;
      o_rom_wr    <= rom_wr_n; // RULE14
      o_rom_addr  <= rom_a_n;
      o_rom_wdata <= i_prg_req.wdata;
      if (vlo_go) begin
        vec_num_reg <= i_vec_num;
      end
    end
  end

  // closed until the protect byte has been read, so nothing leaks early
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prot_reg <= 1'b1;
    end else if (tag_reg == mmcp_pkg::TAG_PROT) begin
      prot_reg <= (i_rom_rdata == `MMCP_PROT_ON); // RULE7 RULE13
    end else if (prot_wr) begin
      prot_reg <= 1'b1; // RULE10
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      vec_lo_reg  <= 8'h00;
      o_vec_addr  <= 16'h0000;
      o_vec_valid <= 1'b0;
    end else begin
      if (tag_reg == mmcp_pkg::TAG_VLO) begin
        vec_lo_reg <= i_rom_rdata;
      end
      if (tag_reg == mmcp_pkg::TAG_VHI) begin
        o_vec_addr <= {i_rom_rdata, vec_lo_reg}; // RULE6
      end
      o_vec_valid <= (tag_reg == mmcp_pkg::TAG_VHI);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_prg_done    <= 1'b0;
      o_prg_refused <= 1'b0;
      o_prg_rdata   <= 8'h00;
    end else begin
      o_prg_done    <= prg_ref | (tag_reg == mmcp_pkg::TAG_PRG);
      o_prg_refused <= prg_ref;
      if (prg_ref) begin
        o_prg_rdata <= `MMCP_FILLER; // RULE14
      end else if (tag_reg == mmcp_pkg::TAG_PRG) begin
        o_prg_rdata <= o_rom_wr ? `MMCP_FILLER : i_rom_rdata;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_sfr_rd    <= 1'b0;
      o_sfr_wr    <= 1'b0;
      o_sfr_addr  <= '0;
      o_sfr_wdata <= 8'h00;
    end else begin
      o_sfr_rd    <= i_cpu_req.rd & rg_sfr; // RULE1
      o_sfr_wr    <= i_cpu_req.wr & rg_sfr;
      o_sfr_addr  <= cpu_ea[`MMCP_SFR_AW-1:0];
      o_sfr_wdata <= i_cpu_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_rd_reg     <= 1'b0;
      s1_acc_reg    <= 1'b0;
      s1_region_reg <= mmcp_pkg::RG_NONE;
    end else begin
      s1_rd_reg     <= i_cpu_req.rd;
      s1_acc_reg    <= cpu_acc;
      s1_region_reg <= cpu_rg;
    end
  end

  // second stage: pick the answering source by the decoded region
  wire logic [7:0] cpu_rd_n = (s1_region_reg == mmcp_pkg::RG_SFR)  ? i_sfr_rdata :
                              (s1_region_reg == mmcp_pkg::RG_RAM)  ? ram_q :
                              (s1_region_reg == mmcp_pkg::RG_NONE) ? `MMCP_NONE_DATA : i_rom_rdata;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cpu_rdata    <= 8'h00;
      o_cpu_rvalid   <= 1'b0;
      o_cpu_unmapped <= 1'b0;
      o_cpu_region   <= mmcp_pkg::RG_NONE;
      o_ready        <= 1'b0;
      o_prot_active  <= 1'b1;
    end else begin
      o_cpu_rdata    <= s1_rd_reg ? cpu_rd_n : 8'h00;
      o_cpu_rvalid   <= s1_rd_reg;
      o_cpu_unmapped <= s1_acc_reg & (s1_region_reg == mmcp_pkg::RG_NONE); // RULE12
      o_cpu_region   <= s1_region_reg;
      o_ready        <= st_run | (state_reg == mmcp_pkg::ST_VEC);
      o_prot_active  <= prot_reg;
    end
  end

endmodule

// *** core/mmcp_cfg.svh ***
/*
  mmcp_cfg.svh: address map, code protect values and vector layout
  of the memory map and code protect block.
  assumes: included by bare name; definitions only.
*/
`ifndef MMCP_CFG_SVH
`define MMCP_CFG_SVH

// short addressing forms: page byte prepended to a one-byte operand
`define MMCP_ZP_PAGE        8'h00
`define MMCP_SP_PAGE        8'hFF

// zero page contents
`define MMCP_SFR_LAST       16'h003F
`define MMCP_SFR_RSV0       16'h0008
`define MMCP_SFR_RSV1       16'h0009
`define MMCP_SFR_RSV2       16'h0033
`define MMCP_SFR_AW         6
`define MMCP_RAM_BASE       16'h0040
`define MMCP_RAM_LAST       16'h023F
`define MMCP_RAM_DEPTH      512
`define MMCP_RAM_AW         9

// program memory
`define MMCP_ROM_BASE       16'hC000
`define MMCP_TEST_LO_LAST   16'hC07F
`define MMCP_TEST_HI_BASE   16'hFFFE
`define MMCP_VEC_BASE       16'hFFDE

// code protect
`define MMCP_PROT_ADDR      16'hFFDB
`define MMCP_PROT_ON        8'h00
`define MMCP_PROT_OFF       8'hFF
`define MMCP_FILLER         8'hFF
`define MMCP_NONE_DATA      8'h00

`endif

// *** core/mmcp_pkg.sv ***
/*
  mmcp_pkg: types of the memory map and code protect block.
  assumes: compiled before every file that names mmcp_pkg.
*/
package mmcp_pkg;

  typedef enum logic [1:0] {
    AM_ABS = 2'b00,
    AM_ZP  = 2'b01,
    AM_SP  = 2'b10
  } mmcp_amode_t;

  typedef enum logic [5:0] {
    RG_NONE = 6'b00_0001,
    RG_SFR  = 6'b00_0010,
    RG_RAM  = 6'b00_0100,
    RG_ROM  = 6'b00_1000,
    RG_VEC  = 6'b01_0000,
    RG_TEST = 6'b10_0000
  } mmcp_region_t;

  typedef enum logic [3:0] {
    ST_PROT  = 4'b0001,
    ST_PWAIT = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_VEC   = 4'b1000
  } mmcp_state_t;

  typedef enum logic [5:0] {
    TAG_NONE = 6'b00_0001,
    TAG_CPU  = 6'b00_0010,
    TAG_PRG  = 6'b00_0100,
    TAG_PROT = 6'b00_1000,
    TAG_VLO  = 6'b01_0000,
    TAG_VHI  = 6'b10_0000
  } mmcp_tag_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    mmcp_amode_t amode;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmcp_cpu_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmcp_prg_req_t;

endpackage

// *** core/mmcp_ram.sv ***
/*
  mmcp_ram: internal data ram, single port, registered read.
  assumes: address already relative to the ram base; no reset on contents.
*/
`timescale 1ns/1ps
`include "mmcp_cfg.svh"

module mmcp_ram (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_we,
  input  wire logic [`MMCP_RAM_AW-1:0]  i_addr,
  input  wire logic [7:0]               i_wdata,
  output logic      [7:0]               o_rdata
);

  // contents are left as power-up leaves them; software loads them first
  logic [7:0] mem [0:`MMCP_RAM_DEPTH-1]; // RULE11

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule

// *** dv/mmcp_top_props.sv ***
/*
  mmcp_top_props: port assertions for mmcp_top.
  assumes: bound to mmcp_top; one clock, synchronous active high reset.
*/
`timescale 1ns/1ps

module mmcp_top_props (
  input logic                    i_core_clk,
  input logic                    i_rst,
  input mmcp_pkg::mmcp_cpu_req_t i_cpu_req,
  input logic [7:0]              o_cpu_rdata,
  input logic                    o_cpu_rvalid,
  input logic                    o_cpu_unmapped,
  input mmcp_pkg::mmcp_region_t  o_cpu_region,
  input logic                    i_vec_req,
  input logic [3:0]              i_vec_num,
  input logic                    o_vec_valid,
  input logic                    o_ready,
  input logic                    o_prg_done,
  input logic                    o_prg_refused,
  input logic [7:0]              o_prg_rdata,
  input logic                    o_prot_active,
  input logic [15:0]             o_rom_addr,
  input logic                    o_rom_rd,
  input logic                    o_rom_wr
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  wire       rd_go = i_cpu_req.rd && o_ready;
  wire [7:0] lo    = i_cpu_req.addr[7:0];
  wire       zp    = i_cpu_req.amode == mmcp_pkg::AM_ZP;
  wire       sp    = i_cpu_req.amode == mmcp_pkg::AM_SP;

  a_rd_answer: assert property (rd_go |-> ##2 o_cpu_rvalid)
    else $error("core read not answered after two cycles");
  a_rvalid_cause: assert property (o_cpu_rvalid |-> $past(i_cpu_req.rd, 2))
    else $error("read data valid without a read");
  a_sfr_hole: assert property (rd_go && zp && lo inside {8'h08, 8'h09, 8'h33}
    |-> ##2 (o_cpu_unmapped && o_cpu_rdata == 8'h00))
    else $error("reserved sfr read not flagged");
  a_zp_ram: assert property (rd_go && zp && lo >= 8'h40 |-> ##2 o_cpu_region == mmcp_pkg::RG_RAM)
    else $error("zero page ram read went elsewhere");
  a_sp_test: assert property (rd_go && sp && lo >= 8'hFE |-> ##2 o_cpu_region == mmcp_pkg::RG_TEST)
    else $error("top two program bytes not test area");
  a_vec_fetch: assert property (i_vec_req && o_ready && !$past(i_vec_req)
    |-> ##1 (o_rom_rd && o_rom_addr == 16'hFFDE + {11'h000, $past(i_vec_num), 1'b0}) ##2 o_vec_valid)
    else $error("vector fetch wrong address or timing");
  a_boot_read: assert property ($fell(i_rst) |-> ##[1:2] (o_rom_rd && o_rom_addr == 16'hFFDB))
    else $error("protect byte not read after reset");
  a_ready_soon: assert property ($fell(i_rst) |-> !o_ready ##[1:4] o_ready)
    else $error("ready not raised after reset");
  a_prot_nowr: assert property (o_prot_active |-> !o_rom_wr)
    else $error("program memory written while protected");
  a_prot_refuse: assert property (o_prg_done && $past(o_prot_active) && $past(o_prot_active, 2)
    |-> o_prg_refused)
    else $error("programmer served while protected");
  a_refuse_fill: assert property (o_prg_done && o_prg_refused |-> o_prg_rdata == 8'hFF)
    else $error("refused programmer read not filler");
endmodule

bind mmcp_top mmcp_top_props u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cpu_req(i_cpu_req), .o_cpu_rdata(o_cpu_rdata),
  .o_cpu_rvalid(o_cpu_rvalid), .o_cpu_unmapped(o_cpu_unmapped), .o_cpu_region(o_cpu_region),
  .i_vec_req(i_vec_req), .i_vec_num(i_vec_num), .o_vec_valid(o_vec_valid), .o_ready(o_ready),
  .o_prg_done(o_prg_done), .o_prg_refused(o_prg_refused), .o_prg_rdata(o_prg_rdata),
  .o_prot_active(o_prot_active), .o_rom_addr(o_rom_addr), .o_rom_rd(o_rom_rd), .o_rom_wr(o_rom_wr)
);

// *** dv/mmcp_mem_model.sv ***
/*
  mmcp_mem_model: program memory and sfr block behind mmcp_top.
  assumes: program memory covers 0xC000-0xFFFF; bench preloads both arrays.
*/
`timescale 1ns/1ps
`include "mmcp_cfg.svh"

module mmcp_mem_model (
  input  logic                    i_core_clk,
  input  logic [15:0]             i_rom_addr,
  input  logic                    i_rom_rd,
  input  logic                    i_rom_wr,
  input  logic [7:0]              i_rom_wdata,
  output logic [7:0]              o_rom_rdata,
  input  logic [`MMCP_SFR_AW-1:0] i_sfr_addr,
  input  logic                    i_sfr_rd,
  input  logic                    i_sfr_wr,
  input  logic [7:0]              i_sfr_wdata,
  output logic [7:0]              o_sfr_rdata
);
  logic [7:0] rom [16384];
  logic [7:0] sfr [64];
  wire  [7:0] rom_byte = rom[i_rom_addr[13:0]];
  wire  [7:0] sfr_byte = sfr[i_sfr_addr];

  // outside a read strobe the bus shows no stale byte, so late sampling is caught
  assign o_rom_rdata = i_rom_rd ? rom_byte : ~rom_byte;
  assign o_sfr_rdata = i_sfr_rd ? sfr_byte : ~sfr_byte;

  always @(posedge i_core_clk) begin
    if (i_rom_wr) begin
      rom[i_rom_addr[13:0]] <= i_rom_wdata;
    end
    if (i_sfr_wr) begin
      sfr[i_sfr_addr] <= i_sfr_wdata;
    end
  end
endmodule

// *** dv/tb_memory_map_rom_code_protect.sv ***
/*
  tb_memory_map_rom_code_protect: self-checking bench for mmcp_top.
  assumes: mmcp_mem_model stands in for program memory and the sfr block.
*/
`timescale 1ns/1ps
`include "mmcp_cfg.svh"

module tb_memory_map_rom_code_protect;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    vec_req = 1'b0;
  logic [3:0]              vec_num = 4'h0;
  mmcp_pkg::mmcp_cpu_req_t cpu_req = '0;
  mmcp_pkg::mmcp_prg_req_t prg_req = '0;
  mmcp_pkg::mmcp_region_t  region;
  logic [15:0]             vec_addr, rom_addr;
  logic [7:0]              cpu_rdata, prg_rdata, rom_wdata, rom_rdata, sfr_wdata, sfr_rdata;
  logic [5:0]              sfr_addr;
  logic                    rvalid, unmapped, vec_valid, ready, prg_done, refused, prot;
  logic                    rom_rd, rom_wr, sfr_rd, sfr_wr;
  int                      errors = 0;
  int                      samples_checked = 0;
  logic [7:0]              ram_ref [int];
  logic [7:0]              rom_ref [int];
  logic [7:0]              sfr_ref [64];

  always #4 clk = ~clk;

  mmcp_top DUT (
    .i_core_clk(clk), .i_rst(rst), .i_cpu_req(cpu_req), .o_cpu_rdata(cpu_rdata), .o_cpu_rvalid(rvalid),
    .o_cpu_unmapped(unmapped), .o_cpu_region(region), .i_vec_req(vec_req), .i_vec_num(vec_num),
    .o_vec_addr(vec_addr), .o_vec_valid(vec_valid), .o_ready(ready), .i_prg_req(prg_req),
    .o_prg_done(prg_done), .o_prg_refused(refused), .o_prg_rdata(prg_rdata), .o_prot_active(prot),
    .o_rom_addr(rom_addr), .o_rom_rd(rom_rd), .o_rom_wr(rom_wr), .o_rom_wdata(rom_wdata),
    .i_rom_rdata(rom_rdata), .o_sfr_addr(sfr_addr), .o_sfr_rd(sfr_rd), .o_sfr_wr(sfr_wr),
    .o_sfr_wdata(sfr_wdata), .i_sfr_rdata(sfr_rdata)
  );

  mmcp_mem_model u_mem (
    .i_core_clk(clk), .i_rom_addr(rom_addr), .i_rom_rd(rom_rd), .i_rom_wr(rom_wr), .i_rom_wdata(rom_wdata),
    .o_rom_rdata(rom_rdata), .i_sfr_addr(sfr_addr), .i_sfr_rd(sfr_rd), .i_sfr_wr(sfr_wr),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata)
  );

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    errors++;
    $display("MISMATCH %0t wait ran out", $time);
    give_verdict();
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [15:0] eff(input mmcp_pkg::mmcp_amode_t am, input logic [15:0] a);
    return am == mmcp_pkg::AM_ZP ? {8'h00, a[7:0]} : am == mmcp_pkg::AM_SP ? {8'hFF, a[7:0]} : a;
  endfunction

  // {valid, unmapped, data, region} expected of a core read
  function automatic logic [15:0] expect_rd(input logic [15:0] e);
    if (e inside {16'h0008, 16'h0009, 16'h0033} || (e > 16'h023F && e < 16'hC000))
      return {2'b11, 8'h00, mmcp_pkg::RG_NONE};
    if (e <= 16'h003F) return {2'b10, sfr_ref[e[5:0]], mmcp_pkg::RG_SFR};
    if (e <= 16'h023F) return {2'b10, ram_ref[e], mmcp_pkg::RG_RAM};
    if (e <= 16'hC07F || e >= 16'hFFFE) return {2'b10, rom_ref[e], mmcp_pkg::RG_TEST};
    if (e >= 16'hFFDE) return {2'b10, rom_ref[e], mmcp_pkg::RG_VEC};
    return {2'b10, rom_ref[e], mmcp_pkg::RG_ROM};
  endfunction

  task automatic cpu(input logic wr, input mmcp_pkg::mmcp_amode_t am, input logic [15:0] a, input logic [7:0] d);
    logic [15:0] e;
    e = eff(am, a);
    cpu_req = '{rd: !wr, wr: wr, amode: am, addr: a, wdata: d};
    tick();
    cpu_req.rd = 1'b0;
    cpu_req.wr = 1'b0;
    tick();
    if (wr && e >= 16'h0040 && e <= 16'h023F) ram_ref[e] = d;
    if (wr && e <= 16'h003F) sfr_ref[e[5:0]] = d;
    if (!wr) check({rvalid, unmapped, cpu_rdata, region}, expect_rd(e), "core read");
    tick();
  endtask

  task automatic vec(input logic [3:0] n);
    logic [15:0] b;
    b = 16'hFFDE + {11'h000, n, 1'b0};
    vec_num = n;
    vec_req = 1'b1;
    tick();
    vec_req = 1'b0;
    repeat (2) tick();
    check({15'h0000, vec_valid}, 16'h0001, "vector valid");
    check(vec_addr, {rom_ref[b + 16'h0001], rom_ref[b]}, "vector address");
    tick();
  endtask

  task automatic prg(input logic we, input logic [15:0] a, input logic [7:0] d, input logic refz,
                     input logic [7:0] exp);
    int n;
    prg_req = '{req: 1'b1, we: we, addr: a, wdata: d};
    n = 0;
    do begin
      tick();
      n++;
    end while (prg_done !== 1'b1 && n < 20);
    if (prg_done !== 1'b1) timed_out();
    check({7'h00, refused, prg_rdata}, {7'h00, refz, exp}, "programmer answer");
    if (we && !refz) rom_ref[a] = d;
    prg_req.req = 1'b0;
    tick();
  endtask

  task automatic do_reset(input logic [7:0] pb);
    int n;
    u_mem.rom[14'h3FDB] = pb;
    rom_ref[16'hFFDB] = pb;
    rst = 1'b1;
    repeat (5) tick();
    rst = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    if (ready !== 1'b1) timed_out();
    check({15'h0000, prot}, {15'h0000, pb == 8'h00}, "protect after reset");
  endtask

  initial begin
    logic [15:0] a;
    logic [7:0]  d;
    static logic [17:0] rd_tab [10] = '{18'h1_0008, 18'h1_0033, 18'h0_1000, 18'h0_C000, 18'h0_C07F,
                                 18'h0_C080, 18'h2_00FE, 18'h2_00FF, 18'h2_00DE, 18'h2_0000};
    void'($urandom(99971));
    for (int i = 16'hC000; i <= 16'hFFFF; i++) begin
      rom_ref[i] = i[7:0] ^ i[15:8];
      u_mem.rom[i - 16'hC000] = i[7:0] ^ i[15:8];
    end
    for (int i = 0; i < 64; i++) begin
      sfr_ref[i] = 8'(i) ^ 8'hA5;
      u_mem.sfr[i] = 8'(i) ^ 8'hA5;
    end
    do_reset(8'hFF);
    cpu(1'b1, mmcp_pkg::AM_ZP, 16'h0010, 8'h3C);
    cpu(1'b0, mmcp_pkg::AM_ZP, 16'h0010, 8'h00);
    cpu(1'b1, mmcp_pkg::AM_ZP, 16'h0080, 8'h96);
    cpu(1'b0, mmcp_pkg::AM_ZP, 16'h0080, 8'h00);
    repeat (8) begin
      a = 16'h0040 + 16'($urandom_range(511));
      // ram powers up undefined, so every byte is written before it is read
      cpu(1'b1, mmcp_pkg::AM_ABS, a, 8'($urandom));
      cpu(1'b0, a <= 16'h00FF ? mmcp_pkg::AM_ZP : mmcp_pkg::AM_ABS, a, 8'h00);
    end
    cpu(1'b1, mmcp_pkg::AM_ABS, 16'hC100, 8'h00);
    // reserved sfr holes are touched only to see them flagged unmapped
    foreach (rd_tab[i]) cpu(1'b0, mmcp_pkg::mmcp_amode_t'(rd_tab[i][17:16]), rd_tab[i][15:0], 8'h00);
    for (int n = 0; n < 16; n++) vec(4'(n));
    prg(1'b0, 16'hC100, 8'h00, 1'b0, rom_ref[16'hC100]);
    d = 8'($urandom);
    prg(1'b1, 16'hC200, d, 1'b0, 8'hFF);
    prg(1'b0, 16'hC200, 8'h00, 1'b0, d);
    prg(1'b0, 16'h0100, 8'h00, 1'b1, 8'hFF);
    // only the protect-on value may close access
    prg(1'b1, 16'hFFDB, 8'h5A, 1'b0, 8'hFF);
    check({15'h0000, prot}, 16'h0000, "protect still open");
    prg(1'b1, 16'hFFDB, 8'h00, 1'b0, 8'hFF);
    repeat (3) tick();
    check({15'h0000, prot}, 16'h0001, "protect set");
    prg(1'b0, 16'hC100, 8'h00, 1'b1, 8'hFF);
    prg(1'b1, 16'hC200, 8'h5A, 1'b1, 8'hFF);
    cpu(1'b0, mmcp_pkg::AM_ABS, 16'hC200, 8'h00);
    do_reset(8'h5A);
    prg(1'b0, 16'hC101, 8'h00, 1'b0, rom_ref[16'hC101]);
    do_reset(8'h00);
    prg(1'b0, 16'hC101, 8'h00, 1'b1, 8'hFF);
    give_verdict();
  end
endmodule
